/* hw/cis_pkg.sv */
// package: switch sizes, connectivity, protection layout and register map
package cis_pkg;
    localparam int NUM_INIT = 15;
    localparam int NUM_TGT = 9;
    localparam int NUM_SLOT = 78;
    localparam int MAX_REG = 16;
    localparam int QOS_W = 4;
    localparam int ADDR_W = 32;
    localparam int GRAN_BYTES = 4096;
    localparam int GRAN_LOG2 = $clog2(GRAN_BYTES);
    localparam int BASE_W = ADDR_W - GRAN_LOG2;
    localparam int TGT_SEL_LSB = 28;
    localparam int AXI_AW = 10;
    localparam logic [4:0] SIZE_MIN = 5'(GRAN_LOG2);
    // reachable targets per initiator, bit t = target t, entry 14 first
    localparam logic [14:0][8:0] CONN_MAP = {
        9'h043, 9'h040, 9'h002, 9'h001, 9'h020, 9'h11c, 9'h1ff, 9'h0cb,
        9'h0cb, 9'h0cb, 9'h0cb, 9'h0d7, 9'h0c0, 9'h0ff, 9'h0ff};
    // protection regions owned by each initiator
    localparam logic [14:0][4:0] REG_CNT = {
        5'h02, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h08, 5'h04,
        5'h04, 5'h08, 5'h08, 5'h04, 5'h08, 5'h10, 5'h10};
    localparam logic [14:0][6:0] REG_FIRST = {
        7'h4c, 7'h4c, 7'h4c, 7'h4c, 7'h4c, 7'h4c, 7'h44, 7'h40,
        7'h3c, 7'h34, 7'h2c, 7'h28, 7'h20, 7'h10, 7'h00};
    // region config word fields
    localparam int CFG_EN = 3;
    localparam int CFG_LOCK = 7;
    localparam int CFG_SIZE = 8;
    // word indices of the status registers, byte address = 4 * index
    localparam logic [7:0] IDX_STAT = 8'h9c;
    localparam logic [7:0] IDX_ADDR = 8'h9d;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    typedef enum logic [1:0] {ACC_READ, ACC_WRITE, ACC_EXEC} cis_acc_t;
endpackage

/* hw/cis_chk_if.sv */
// interface: granted access and region set handed to the region matcher
`timescale 1ns/1ps
interface cis_chk_if;
    logic [cis_pkg::ADDR_W-1:0]                      addr;
    cis_pkg::cis_acc_t                               kind;
    logic [cis_pkg::MAX_REG-1:0]                     slotOn;
    logic [cis_pkg::MAX_REG-1:0][cis_pkg::BASE_W-1:0] base;
    logic [cis_pkg::MAX_REG-1:0][4:0]                size;
    logic [cis_pkg::MAX_REG-1:0][2:0]                perm;
    logic                                            allow;
    modport sw  (output addr, kind, slotOn, base, size, perm, input allow);
    modport chk (input addr, kind, slotOn, base, size, perm, output allow);
endinterface

/* hw/cis_region_match.sv */
// module: power-of-two region matcher, lowest matching region decides
`timescale 1ns/1ps
module cis_region_match (
    cis_chk_if.chk chk // granted access and its regions
);
    always_comb begin
        logic [cis_pkg::ADDR_W-1:0] mask;
        logic [cis_pkg::ADDR_W-1:0] diff;
        mask = '0;
        diff = '0;
        chk.allow = 1'b0;
        // walk down so the lowest matching region is the last to decide
        for (int k = cis_pkg::MAX_REG - 1; k >= 0; k--) begin
            mask = 32'hffff_ffff << chk.size[k];
            diff = chk.addr ^ {chk.base[k], {cis_pkg::GRAN_LOG2{1'b0}}};
            if (chk.slotOn[k] && ((diff & mask) == 32'h0)) begin
                case (chk.kind)
                    cis_pkg::ACC_READ:  chk.allow = chk.perm[k][0];
                    cis_pkg::ACC_WRITE: chk.allow = chk.perm[k][1];
                    cis_pkg::ACC_EXEC:  chk.allow = chk.perm[k][2];
                    default:            chk.allow = 1'b0;
                endcase
            end
        end
    end
endmodule

/* hw/cis_io_switch.sv */
// module: central I/O switch with QoS arbitration and region protection
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module cis_io_switch #(
    parameter int DATA_W = 64 // data width of every initiator and target port
) (
    input  wire logic                           clock,        // system clock
    input  wire logic                           rst_n,        // sync reset
    input  wire logic                           ce,           // clock enable
    input  wire logic [cis_pkg::AXI_AW-1:0]     s_axi_awaddr, // wr address
    input  wire logic                           s_axi_awvalid,// wr addr valid
    output logic                                s_axi_awready,// wr addr ready
    input  wire logic [31:0]                    s_axi_wdata,  // wr data
    input  wire logic [3:0]                     s_axi_wstrb,  // byte enables
    input  wire logic                           s_axi_wvalid, // wr data valid
    output logic                                s_axi_wready, // wr data ready
    output logic [1:0]                          s_axi_bresp,  // wr response
    output logic                                s_axi_bvalid, // wr resp valid
    input  wire logic                           s_axi_bready, // wr resp ready
    input  wire logic [cis_pkg::AXI_AW-1:0]     s_axi_araddr, // rd address
    input  wire logic                           s_axi_arvalid,// rd addr valid
    output logic                                s_axi_arready,// rd addr ready
    output logic [31:0]                         s_axi_rdata,  // rd data
    output logic [1:0]                          s_axi_rresp,  // rd response
    output logic                                s_axi_rvalid, // rd data valid
    input  wire logic                           s_axi_rready, // rd data ready
    input  wire logic [14:0]                    initReqValid, // request
    output logic [14:0]                         initReqReady, // request taken
    input  wire logic [14:0][31:0]              initAddr,     // address
    input  wire logic [14:0][1:0]               initKind,     // rd/wr/fetch
    input  wire logic [14:0][3:0]               initQos,      // priority
    input  wire logic [14:0][DATA_W-1:0]        initWdata,    // write data
    output logic [14:0]                         initRespValid,// answer pulse
    output logic [DATA_W-1:0]                   initRdata,    // read data
    output logic                                initRespErr,  // error answer
    output logic [8:0]                          tgtReqValid,  // request
    input  wire logic [8:0]                     tgtReqReady,  // taken
    output logic [31:0]                         tgtAddr,      // address
    output logic [1:0]                          tgtKind,      // rd/wr/fetch
    output logic [3:0]                          tgtQos,       // priority
    output logic [3:0]                          tgtInitId,    // initiator
    output logic [DATA_W-1:0]                   tgtWdata,     // write data
    input  wire logic [8:0]                     tgtRespValid, // answer
    output logic [8:0]                          tgtRespReady, // answer taken
    input  wire logic [8:0][DATA_W-1:0]         tgtRdata,     // read data
    input  wire logic [8:0]                     tgtRespErr    // error answer
);
    if (DATA_W < 8 || DATA_W % 8 != 0) begin : g_bad_width
        $error("DATA_W must be a positive multiple of 8");
    end

    typedef enum {ST_IDLE, ST_CHECK, ST_FWD, ST_WAIT, ST_DONE} cis_state_t;

    localparam logic [14:0] ONE_I = 15'h0001;
    localparam logic [8:0]  ONE_T = 9'h001;

    cis_state_t        state_ff;
    cis_state_t        nxt_state;
    logic [3:0]        gntId_ff;
    logic [31:0]       reqAddr_ff;
    cis_pkg::cis_acc_t reqKind_ff;
    logic [3:0]        reqQos_ff;
    logic [DATA_W-1:0] reqWdata_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic              respErr_ff;
    logic              winValid;
    logic [3:0]        winId;
    logic [3:0]        winQos;
    logic [3:0]        hiQos;
    logic [3:0]        tgtSel;
    logic              prot;
    logic              tgtOk;
    logic              pass;

    logic [cis_pkg::BASE_W-1:0] regBase_ff [cis_pkg::NUM_SLOT];
    logic [4:0]                 regSize_ff [cis_pkg::NUM_SLOT];
    logic [2:0]                 regPerm_ff [cis_pkg::NUM_SLOT];
    logic                       regEn_ff   [cis_pkg::NUM_SLOT];
    logic                       regLock_ff [cis_pkg::NUM_SLOT];
    logic                       denyValid_ff;
    logic [9:0]                 denyInfo_ff;
    logic [31:0]                denyAddr_ff;

    logic                       awHeld_ff;
    logic [cis_pkg::AXI_AW-1:0] awAddr_ff;
    logic                       wHeld_ff;
    logic [31:0]                wData_ff;
    logic [3:0]                 wStrb_ff;
    logic                       bvalid_ff;
    logic [1:0]                 bresp_ff;
    logic                       rvalid_ff;
    logic [31:0]                rdataAxi_ff;
    logic [1:0]                 rresp_ff;
    logic                       wrFire;
    logic [7:0]                 wIdx;
    logic [6:0]                 wSlot;
    logic [31:0]                wMerged;
    logic [7:0]                 rIdx;

    cis_chk_if chkIf ();

    cis_region_match u_match (
        .chk (chkIf)
    );

    // register word as software sees it
    function automatic logic [31:0] regWord(input logic [7:0] idx);
        logic [6:0] s;
        s = idx[7:1];
        regWord = 32'h0;
        if (idx == cis_pkg::IDX_STAT) begin
            regWord = {denyValid_ff, 21'h0, denyInfo_ff};
        end else if (idx == cis_pkg::IDX_ADDR) begin
            regWord = denyAddr_ff;
        end else if (s < 7'(cis_pkg::NUM_SLOT)) begin
            if (idx[0]) begin
                regWord = {regBase_ff[s], {cis_pkg::GRAN_LOG2{1'b0}}};
            end else begin
                regWord = {19'h0, regSize_ff[s], regLock_ff[s], 3'h0,
                           regEn_ff[s], regPerm_ff[s]};
            end
        end
    endfunction

    function automatic logic mapped(input logic [7:0] idx);
        mapped = (idx[7:1] < 7'(cis_pkg::NUM_SLOT)) ||
                 (idx == cis_pkg::IDX_STAT) || (idx == cis_pkg::IDX_ADDR);
    endfunction

    // priority arbiter, ties go to the lowest initiator number
    always_comb begin
        winValid = 1'b0;
        winId = 4'h0;
        winQos = 4'h0;
        for (int i = 0; i < cis_pkg::NUM_INIT; i++) begin
            if (initReqValid[i] && (!winValid || initQos[i] > winQos)) begin
                winValid = 1'b1;
                winId = 4'(i);
                winQos = initQos[i];
            end
        end
    end

    assign initReqReady = (state_ff == ST_IDLE && ce && winValid) ?
                          (ONE_I << winId) : '0;

    // hand the granted initiator's own region set to the matcher
    always_comb begin
        logic [6:0] slot;
        slot = 7'h0;
        chkIf.addr = reqAddr_ff;
        chkIf.kind = reqKind_ff;
        for (int k = 0; k < cis_pkg::MAX_REG; k++) begin
            slot = 7'(int'(cis_pkg::REG_FIRST[gntId_ff]) + k);
            if (slot >= 7'(cis_pkg::NUM_SLOT)) begin
                slot = 7'h0;
            end
            chkIf.slotOn[k] = (5'(k) < cis_pkg::REG_CNT[gntId_ff]) &&
                              regEn_ff[slot];
            chkIf.base[k] = regBase_ff[slot];
            chkIf.size[k] = regSize_ff[slot];
            chkIf.perm[k] = regPerm_ff[slot];
        end
    end

    // top nibble of the address selects the target port
    assign tgtSel = reqAddr_ff[cis_pkg::TGT_SEL_LSB +: 4];
    assign prot = cis_pkg::REG_CNT[gntId_ff] != 5'h0;
    assign tgtOk = (tgtSel < 4'(cis_pkg::NUM_TGT)) &&
                   cis_pkg::CONN_MAP[gntId_ff][tgtSel];
    assign pass = tgtOk && (!prot || chkIf.allow);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (winValid) begin
                    nxt_state = ST_CHECK;
                end
            end
            ST_CHECK: nxt_state = pass ? ST_FWD : ST_DONE;
            ST_FWD: begin
                if (tgtReqReady[tgtSel]) begin
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (tgtRespValid[tgtSel]) begin
                    nxt_state = ST_DONE;
                end
            end
            ST_DONE: nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    // capture the granted request
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            gntId_ff <= 4'h0;
            reqAddr_ff <= 32'h0;
            reqKind_ff <= cis_pkg::ACC_READ;
            reqQos_ff <= 4'h0;
            reqWdata_ff <= '0;
        end else if (ce && state_ff == ST_IDLE && winValid) begin
            gntId_ff <= winId;
            reqAddr_ff <= initAddr[winId];
            reqKind_ff <= cis_pkg::cis_acc_t'(initKind[winId]);
            reqQos_ff <= winQos;
            reqWdata_ff <= initWdata[winId];
        end
    end

    // answer to the initiator
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_ff <= '0;
            respErr_ff <= 1'b0;
        end else if (ce) begin
            if (state_ff == ST_CHECK && !pass) begin
                rdata_ff <= '0;
                respErr_ff <= 1'b1;
            end else if (state_ff == ST_WAIT && tgtRespValid[tgtSel]) begin
                rdata_ff <= tgtRdata[tgtSel];
                respErr_ff <= tgtRespErr[tgtSel];
            end
        end
    end

    assign initRespValid = (state_ff == ST_DONE && ce) ?
                           (ONE_I << gntId_ff) : '0;
    assign initRdata = rdata_ff;
    assign initRespErr = respErr_ff;
    assign tgtReqValid = (state_ff == ST_FWD) ? (ONE_T << tgtSel) : '0;
    assign tgtRespReady = (state_ff == ST_WAIT && ce) ? (ONE_T << tgtSel) : '0;
    assign tgtAddr = reqAddr_ff;
    assign tgtKind = reqKind_ff;
    assign tgtQos = reqQos_ff;
    assign tgtInitId = gntId_ff;
    assign tgtWdata = reqWdata_ff;

    // last refused access; software clears valid, a new refusal wins
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            denyValid_ff <= 1'b0;
            denyInfo_ff <= 10'h0;
            denyAddr_ff <= 32'h0;
        end else if (ce) begin
            if (state_ff == ST_CHECK && !pass) begin
                denyValid_ff <= 1'b1;
                denyInfo_ff <= {reqKind_ff, gntId_ff, tgtSel};
                denyAddr_ff <= reqAddr_ff;
            end else if (wrFire && wIdx == cis_pkg::IDX_STAT) begin
                denyValid_ff <= 1'b0;
            end
        end
    end

    // register bus: address and data taken in either order
    assign s_axi_awready = ce && !awHeld_ff && !bvalid_ff;
    assign s_axi_wready = ce && !wHeld_ff && !bvalid_ff;
    assign wrFire = ce && awHeld_ff && wHeld_ff && !bvalid_ff;
    assign wIdx = awAddr_ff[cis_pkg::AXI_AW-1:2];
    assign wSlot = wIdx[7:1];
    assign rIdx = s_axi_araddr[cis_pkg::AXI_AW-1:2];

    always_comb begin
        logic [31:0] old;
        old = regWord(wIdx);
        for (int b = 0; b < 4; b++) begin
            wMerged[b*8 +: 8] = wStrb_ff[b] ? wData_ff[b*8 +: 8] : old[b*8 +: 8];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            awHeld_ff <= 1'b0;
            awAddr_ff <= '0;
            wHeld_ff <= 1'b0;
            wData_ff <= 32'h0;
            wStrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= cis_pkg::RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_ff <= 1'b1;
                awAddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_ff <= 1'b1;
                wData_ff <= s_axi_wdata;
                wStrb_ff <= s_axi_wstrb;
            end
            if (wrFire) begin
                awHeld_ff <= 1'b0;
                wHeld_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= mapped(wIdx) ? cis_pkg::RESP_OKAY :
                                           cis_pkg::RESP_DECERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rvalid_ff <= 1'b0;
            rdataAxi_ff <= 32'h0;
            rresp_ff <= cis_pkg::RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_ff <= 1'b1;
                rdataAxi_ff <= regWord(rIdx);
                rresp_ff <= mapped(rIdx) ? cis_pkg::RESP_OKAY :
                                           cis_pkg::RESP_DECERR;
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    assign s_axi_arready = ce && !rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdataAxi_ff;
    assign s_axi_rresp = rresp_ff;

    // region registers; a locked region keeps its contents
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            for (int s = 0; s < cis_pkg::NUM_SLOT; s++) begin
                regBase_ff[s] <= '0;
                regSize_ff[s] <= cis_pkg::SIZE_MIN;
                regPerm_ff[s] <= 3'h0;
                regEn_ff[s] <= 1'b0;
                regLock_ff[s] <= 1'b0;
            end
        end else if (wrFire && wSlot < 7'(cis_pkg::NUM_SLOT) &&
                     !regLock_ff[wSlot]) begin
            if (wIdx[0]) begin
                regBase_ff[wSlot] <= wMerged[31:cis_pkg::GRAN_LOG2];
            end else begin
                regPerm_ff[wSlot] <= wMerged[2:0];
                regEn_ff[wSlot] <= wMerged[cis_pkg::CFG_EN];
                regLock_ff[wSlot] <= wMerged[cis_pkg::CFG_LOCK];
                regSize_ff[wSlot] <=
                    (wMerged[cis_pkg::CFG_SIZE +: 5] < cis_pkg::SIZE_MIN) ?
                    cis_pkg::SIZE_MIN : wMerged[cis_pkg::CFG_SIZE +: 5];
            end
        end
    end

    // helper logic for the checks below
    logic        lkSeen_ff;
    logic [7:0]  lkIdx_ff;
    logic [31:0] lkWord_ff;

    always_comb begin
        hiQos = 4'h0;
        for (int i = 0; i < cis_pkg::NUM_INIT; i++) begin
            if (initReqValid[i] && initQos[i] > hiQos) begin
                hiQos = initQos[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lkSeen_ff <= 1'b0;
            lkIdx_ff <= 8'h0;
            lkWord_ff <= 32'h0;
        end else if (ce) begin
            lkSeen_ff <= wrFire && wSlot < 7'(cis_pkg::NUM_SLOT) &&
                         regLock_ff[wSlot];
            lkIdx_ff <= wIdx;
            lkWord_ff <= regWord(wIdx);
        end
    end

    default clocking cb @(posedge clock iff ce);
    endclocking
    default disable iff (!rst_n);

    sequence s_deny;
        state_ff == ST_CHECK && !pass;
    endsequence

    sequence s_err_answer;
        initRespValid == (ONE_I << gntId_ff) && initRespErr &&
        tgtReqValid == 9'h000;
    endsequence

    AST_QOS_GRANT: assert property (
        (state_ff == ST_IDLE && winValid) |=>
        reqQos_ff == $past(hiQos) && $past(initReqReady) == (ONE_I << gntId_ff))
        else $error("grant did not go to the highest priority");

    AST_ONLY_CONNECTED: assert property (
        (tgtReqValid != 9'h000) |->
        $onehot(tgtReqValid) && cis_pkg::CONN_MAP[gntId_ff][tgtSel])
        else $error("request forwarded over an unconnected pair");

    AST_UNMAPPED_ERR: assert property (
        (state_ff == ST_CHECK && tgtSel >= 4'(cis_pkg::NUM_TGT)) |=>
        initRespErr)
        else $error("access to no target did not end in error");

    AST_CHECK_BEFORE_FWD: assert property (
        (state_ff == ST_FWD && $past(state_ff) == ST_CHECK) |->
        (!$past(prot) || $past(chkIf.allow)))
        else $error("protected access forwarded without permission");

    AST_REGION_SET: assert property (
        (chkIf.slotOn >> cis_pkg::REG_CNT[gntId_ff]) == 16'h0000)
        else $error("region outside the initiator's own set used");

    AST_MIN_GRAIN: assert property (
        (wrFire && !wIdx[0] && wSlot < 7'(cis_pkg::NUM_SLOT)) |=>
        regSize_ff[$past(wSlot)] >= cis_pkg::SIZE_MIN)
        else $error("region smaller than the minimum granule");

    AST_LOCK_KEEP: assert property (
        lkSeen_ff |-> regWord(lkIdx_ff) == lkWord_ff)
        else $error("locked region changed by a write");

    AST_DENY_ERROR: assert property (
        s_deny |=> s_err_answer ##1 state_ff == ST_IDLE)
        else $error("refused access not answered with error");

    AST_FWD_HOLD: assert property (
        (tgtReqValid != 9'h000 && (tgtReqValid & tgtReqReady) == 9'h000) |=>
        $stable(tgtReqValid) && $stable(tgtAddr))
        else $error("target request dropped before it was taken");
endmodule

/* tb/cis_tgt_model.sv */
// target-side model: takes each request, answers on the next edge
`timescale 1ns/1ps
module cis_tgt_model (
    input  wire logic             clock, // clock
    input  wire logic             rst_n, // reset
    input  wire logic [8:0]       rqV,   // request
    output logic      [8:0]       rqR,   // taken
    input  wire logic [31:0]      adr,   // address
    output logic      [8:0]       rsV,   // answer
    input  wire logic [8:0]       rsR,   // answer taken
    output logic      [8:0][63:0] rd,    // read data
    output logic      [8:0]       err    // error answer
);
    logic [31:0] adr_ff;
    logic        flip_ff;
    always_ff @(posedge clock) begin
        rqR <= rst_n ? rqV & ~rqR : '0;
        rsV <= rst_n ? (rsV & ~rsR) | (rqV & rqR) : '0;
        flip_ff <= rst_n ? ~flip_ff : 1'b0;
        if (|(rqV & rqR))
            adr_ff <= adr;
    end
    // released data toggles so stale values never match
    always_comb
        for (int t = 0; t < 9; t++)
            rd[t] = rsV[t] ? {adr_ff, ~adr_ff} : {64{flip_ff}};
    assign err = '0;
endmodule

/* tb/test_cis_io_switch.sv */
// bench for the central switch: routing, protection, qos, registers
`timescale 1ns/1ps
module test_cis_io_switch;
    logic clock = 0, rst_n = 0, awV = 0, wV = 0, bR = 0, arV = 0, rR = 0;
    logic awR, wR, bV, arR, rV, iErr;
    logic [9:0] awA = '0, arA = '0;
    logic [31:0] wD = '0, rD, tA;
    logic [1:0] bRs, rRs, tK;
    logic [3:0] tQ, tI;
    logic [14:0] iV = '0, iR, iRsV;
    logic [14:0][31:0] iA = '0;
    logic [14:0][1:0] iK = '0;
    logic [14:0][3:0] iQ = '0;
    logic [63:0] iRd;
    logic [8:0] tV, tR, tRsV, tRsR, tErr;
    logic [8:0][63:0] tRd;
    logic [11:0] cn [8] = '{12'h980, 12'h901, 12'ha50, 12'ha41,
                            12'hc10, 12'hd60, 12'hd71, 12'hba1};
    int nMismatch = 0, samplesChecked = 0, nFwd = 0, cyc = 0;
    cis_io_switch i_dut (.clock, .rst_n, .ce(1'b1), .s_axi_awaddr(awA),
        .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wD),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wV), .s_axi_wready(wR),
        .s_axi_bresp(bRs), .s_axi_bvalid(bV), .s_axi_bready(bR),
        .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arR),
        .s_axi_rdata(rD), .s_axi_rresp(rRs), .s_axi_rvalid(rV),
        .s_axi_rready(rR), .initReqValid(iV), .initReqReady(iR),
        .initAddr(iA), .initKind(iK), .initQos(iQ), .initWdata('0),
        .initRespValid(iRsV), .initRdata(iRd), .initRespErr(iErr),
        .tgtReqValid(tV), .tgtReqReady(tR), .tgtAddr(tA), .tgtKind(tK),
        .tgtQos(tQ), .tgtInitId(tI), .tgtWdata(), .tgtRespValid(tRsV),
        .tgtRespReady(tRsR), .tgtRdata(tRd), .tgtRespErr(tErr));
    cis_tgt_model i_tgt (.clock, .rst_n, .rqV(tV), .rqR(tR), .adr(tA),
        .rsV(tRsV), .rsR(tRsR), .rd(tRd), .err(tErr));
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        nFwd += $countones(tV & tR);
        cyc++;
        if (cyc == 20000) begin
            nMismatch++;
            tallyAndFinish();
        end
    end
    task automatic chk(input logic [64:0] g, input logic [64:0] e);
        samplesChecked++;
        if (g !== e) begin
            nMismatch++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        {awA, wD, awV, wV, bR} <= {a, d, 3'h7};
        do begin
            @(posedge clock);
            if (awR) awV <= 0;
            if (wR) wV <= 0;
        end while (!bV);
        chk(65'(bRs), 65'(0));
    endtask
    task automatic rdc(input logic [9:0] a, input logic [33:0] e);
        {arA, arV, rR} <= {a, 2'h3};
        do begin
            @(posedge clock);
            if (arR) arV <= 0;
        end while (!rV);
        chk(65'({rRs, rD}), 65'(e));
    endtask
    task automatic req(input int i, input logic [31:0] a,
                       input logic [1:0] k, input logic e);
        int f;
        f = nFwd;
        {iA[i], iK[i], iV[i]} <= {a, k, 1'b1};
        do begin
            @(posedge clock);
            if (iR[i]) iV[i] <= 0;
        end while (!iRsV[i]);
        chk(65'(iErr), 65'(e));
        chk(65'(nFwd - f), 65'(!e));
        chk(65'(tK), 65'(k));
        if (e || k == 2'h0) chk(65'(iRd), e ? '0 : 65'({a, ~a}));
    endtask
    task automatic qos();
        {iA[9], iA[11], iK[9], iK[11]} <= {32'h20000000, 32'h0, 4'h0};
        {iQ[9], iQ[11], iV} <= {4'h1, 4'h5, 15'h0a00};
        do begin
            @(posedge clock);
            iV <= iV & ~iR;
        end while (!(|iRsV));
        chk(65'(iRsV), 65'h800);
        chk(65'(tQ), 65'h5);
        chk(65'(tI), 65'hb);
        do begin
            @(posedge clock);
            iV <= iV & ~iR;
        end while (!iRsV[9]);
        chk(65'(tQ), 65'h1);
    endtask
    task automatic tallyAndFinish();
        if (nMismatch == 0 && samplesChecked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1;
        @(posedge clock);
        rdc(10'h028, 34'hc00);
        wr(10'h028, 32'h500);
        rdc(10'h028, 34'hc00);
        rdc(10'h3fc, {2'h3, 32'h0});
        foreach (cn[j])
            req(cn[j][11:8], {cn[j][7:4], 28'h100}, 2'h0, cn[j][0]);
        rdc(10'h270, 34'h0800000ba);
        rdc(10'h274, 34'h0a0000100);
        wr(10'h270, 32'h0);
        rdc(10'h270, 34'h0ba);
        req(0, 32'h1000, 2'h0, 1);
        wr(10'h004, 32'h1000);
        wr(10'h000, 32'hc09);
        wr(10'h008, 32'h100b);
        req(0, 32'h1000, 2'h0, 0);
        req(0, 32'h1000, 2'h1, 1);
        req(0, 32'h2000, 2'h1, 0);
        req(0, 32'h2000, 2'h2, 1);
        req(0, 32'h10000, 2'h0, 1);
        wr(10'h000, 32'hc89);
        wr(10'h000, 32'h0);
        rdc(10'h000, 34'hc89);
        req(0, 32'h1000, 2'h0, 0);
        qos();
        tallyAndFinish();
    end
endmodule
